// file: tb/host_reader.sv
// Host side model draining the record stream
`timescale 1ns/1ps
module host_reader
  import tag_recorder_pkg::*;
(
  // Clock
  input wire logic    clock,
  // Pacing
  input wire logic    stall,
  input wire logic    slow,
  // Record stream
  input wire record_t recData,
  input wire logic    recValid,
  output logic        recReady
);
  record_t got[$];
  logic    phase = 1'h0;
  // Reads continuously unless stalled; slow takes every other cycle
  always @(posedge clock) begin
    if (recValid && recReady) got.push_back(recData);
    phase <= !phase;
    recReady <= #1 !stall && (!slow || phase);
  end
  // No divider here, so the sync input stays undivided
endmodule : host_reader

// file: tb/recorder_monitor.sv
// Port checks for the time tag recorder
`timescale 1ns/1ps
module recorder_monitor
  import tag_recorder_pkg::*;
#(
  parameter int NUM_CHANS = NUM_CHANS_DEF
) (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 nrst,
  // Control and detectors
  input wire logic                 measStart,
  input wire logic                 measStop,
  input wire logic                 lossClear,
  input wire logic [NUM_CHANS-1:0] photonInputChannels,
  // Stream and status
  input wire record_t              recData,
  input wire logic                 recValid,
  input wire logic                 recReady,
  input wire logic                 running,
  input wire logic                 lossFlag,
  input wire logic                 overrunFlag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_hold;
    recValid && !recReady |=> recValid && $stable(recData);
  endproperty
  a_hold: assert property (p_hold) else $error("record dropped");
  property p_start;
    measStart && !running |=> running;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop;
    measStop |=> !running;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_ovf;
    recValid && recData.kind == KIND_OVERFLOW |-> recData.chan == 6'h00 && recData.tag == 25'h0000000;
  endproperty
  a_ovf: assert property (p_ovf) else $error("bad overflow record");
  property p_chan;
    recValid && recData.kind == KIND_EVENT |-> recData.chan < NUM_CHANS;
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_overrun;
    $rose(overrunFlag) |-> !running && $past(running);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun kept running");
  property p_overrun_hold;
    overrunFlag && !measStart |=> overrunFlag;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost");
  property p_loss_hold;
    lossFlag && !lossClear && !measStart |=> lossFlag;
  endproperty
  a_loss_hold: assert property (p_loss_hold) else $error("loss lost");
  property p_loss_clear;
    lossClear && !(|photonInputChannels) && !$past(|photonInputChannels) |=> !lossFlag;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("loss not cleared");
endmodule : recorder_monitor

// file: tb/testbench.sv
// Self-checking bench for the time tag recorder
`timescale 1ns/1ps
module testbench;
  import tag_recorder_pkg::*;
  localparam int NCH = 9;
  // 5 ps variant lets the tag wrap within a short run
  localparam int UNIT = 5;
  localparam int STEP = CLK_PERIOD_PS / UNIT;
  logic           clock = 1'h0;
  logic           nrst = 1'h0;
  logic           measStart = 1'h0;
  logic           measStop = 1'h0;
  logic           lossClear = 1'h0;
  logic [NCH-1:0] photonInputChannels = '0;
  logic           stall = 1'h0;
  logic           slow = 1'h0;
  record_t        recData;
  logic           recValid, recReady, running, lossFlag, overrunFlag;
  int             n_errors = 0;
  int             num_checks = 0;
  int             cyc = 0;
  int             startE = 0;
  always #4 clock = !clock;
  always @(posedge clock) cyc <= cyc + 1;
  // Small buffers so fill and overrun happen quickly
  time_tag_recorder #(.NUM_CHANS(NCH), .FRONT_DEPTH(8), .SHARED_DEPTH(16), .TIME_UNIT_PS(UNIT)) u_time_tag_recorder (
    .clock, .nrst, .measStart, .measStop, .lossClear, .photonInputChannels,
    .recData, .recValid, .recReady, .running, .lossFlag, .overrunFlag);
  host_reader host (.clock, .stall, .slow, .recData, .recValid, .recReady);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // Tag of an event driven now, sampled at the next edge
  function automatic int tagNow();
    return (cyc - startE) * STEP;
  endfunction : tagNow
  function automatic logic [31:0] seenCount(input int ch, input int tag);
    logic [31:0] n;
    n = '0;
    foreach (host.got[i]) if (host.got[i] === {KIND_EVENT, 6'(ch), 25'(tag)}) n++;
    return n;
  endfunction : seenCount
  task automatic test_start;
    measStart = 1'h1;
    step(1);
    startE = cyc;
    measStart = 1'h0;
    check(running, 1'h1);
    $display("test_start done");
  endtask : test_start
  task automatic test_coincident;
    int t;
    host.got.delete();
    step(1);
    t = tagNow();
    photonInputChannels = 9'h101;
    step(1);
    photonInputChannels = '0;
    step(12);
    check(seenCount(0, t), 1);
    check(seenCount(8, t), 1);
    check(host.got.size(), 2);
    $display("test_coincident done");
  endtask : test_coincident
  task automatic test_dead;
    int t;
    host.got.delete();
    slow = 1'h1;
    t = tagNow();
    photonInputChannels = 9'h028;
    step(1);
    photonInputChannels = 9'h008;
    step(3);
    photonInputChannels = '0;
    step(20);
    check(seenCount(3, t), 1);
    check(seenCount(3, t + 2 * STEP), 1);
    check(seenCount(5, t), 1);
    check(host.got.size(), 3);
    slow = 1'h0;
    $display("test_dead done");
  endtask : test_dead
  task automatic test_loss;
    int last[NCH];
    int bad;
    host.got.delete();
    photonInputChannels = '1;
    step(40);
    photonInputChannels = '0;
    step(150);
    check(lossFlag, 1'h1);
    check(overrunFlag, 1'h0);
    foreach (last[i]) last[i] = -1;
    bad = 0;
    foreach (host.got[i]) begin
      if (int'(host.got[i].tag) <= last[host.got[i].chan]) bad++;
      last[host.got[i].chan] = host.got[i].tag;
    end
    check(bad, 0);
    lossClear = 1'h1;
    step(1);
    lossClear = 1'h0;
    step(1);
    check(lossFlag, 1'h0);
    $display("test_loss done");
  endtask : test_loss
  task automatic test_overrun;
    stall = 1'h1;
    photonInputChannels = '1;
    step(6);
    photonInputChannels = '0;
    // Shared buffer fills about 18 cycles after the burst starts
    step(20);
    check(running, 1'h0);
    check(overrunFlag, 1'h1);
    stall = 1'h0;
    step(100);
    test_start();
    check(overrunFlag, 1'h0);
    measStop = 1'h1;
    step(1);
    measStop = 1'h0;
    host.got.delete();
    photonInputChannels = 9'h002;
    step(1);
    photonInputChannels = '0;
    step(10);
    check(host.got.size(), 0);
    $display("test_overrun done");
  endtask : test_overrun
  task automatic test_wrap;
    int t;
    int nOvf;
    test_start();
    host.got.delete();
    step((2 ** TAG_W) / STEP);
    t = tagNow();
    photonInputChannels = 9'h004;
    step(1);
    photonInputChannels = 9'h010;
    step(1);
    photonInputChannels = '0;
    step(10);
    nOvf = 0;
    foreach (host.got[i]) if (host.got[i].kind === KIND_OVERFLOW) nOvf++;
    check(nOvf, 1);
    check(host.got[0], {KIND_OVERFLOW, 6'h00, 25'h0000000});
    check(seenCount(2, t), 1);
    check(seenCount(4, t + STEP), 1);
    check(host.got.size(), 3);
    $display("test_wrap done");
  endtask : test_wrap
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (16) @(posedge clock);
    #1;
    nrst = 1'h1;
    step(3);
    test_start();
    test_coincident();
    test_dead();
    test_loss();
    test_overrun();
    test_wrap();
    finish_test();
  end
  // Run needs about 21,500 cycles, mostly the wait for the tag to wrap
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule : testbench
bind time_tag_recorder recorder_monitor #(.NUM_CHANS(NUM_CHANS)) u_recorder_monitor (
  .clock, .nrst, .measStart, .measStop, .lossClear, .photonInputChannels,
  .recData, .recValid, .recReady, .running, .lossFlag, .overrunFlag);

// file: verilog/rec_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rec_fifo
  import tag_recorder_pkg::*;
#(
  parameter int WIDTH = REC_W,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rstN,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("rec_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count_q != FULL);
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  // Storage has no reset; only pointers and count matter
  always_ff @(posedge clock) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      count_q <= '0;
    end else if (doWr && !doRd) begin
      count_q <= count_q + 1'b1;
    end else if (doRd && !doWr) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule : rec_fifo

// file: verilog/tag_recorder_pkg.sv
// Shared constants and record layout for the absolute time tag recorder
package tag_recorder_pkg;

  // Record word layout
  localparam int REC_W      = 32;
  localparam int CHAN_W     = 6;
  localparam int TAG_W      = 25;
  localparam int MAX_CHANS  = 64;

  // Marker bit values in the spare bit
  localparam logic KIND_EVENT    = 1'h0;
  localparam logic KIND_OVERFLOW = 1'h1;

  // Timing
  localparam int CLK_PERIOD_PS     = 8000;
  localparam int RES_PS            = 80;
  localparam int TAG_STEP          = CLK_PERIOD_PS / RES_PS;
  localparam int CHANNEL_DEAD_TIME_PS = 650;
  localparam int DEAD_CYC          = (CHANNEL_DEAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DEAD_W            = $clog2(DEAD_CYC + 1);

  // Buffer sizes and channel count
  localparam int FRONT_DEPTH_DEF  = 2048;
  localparam int SHARED_DEPTH_DEF = 134217728;
  localparam int NUM_CHANS_DEF    = 9;

  // Reset values
  localparam logic [TAG_W-1:0] TAG_RESET = 25'h0000000;
  localparam logic [DEAD_W-1:0] DEAD_IDLE = '0;

  typedef struct packed {
    logic              kind;
    logic [CHAN_W-1:0] chan;
    logic [TAG_W-1:0]  tag;
  } record_t;

  localparam record_t REC_RESET = '{kind: KIND_EVENT, chan: '0, tag: TAG_RESET};

endpackage : tag_recorder_pkg

// file: verilog/time_tag_recorder.sv
// Absolute time tag event recorder: capture, per-channel burst buffers, merge, shared buffer
//
// Notes on behaviour
// - Every input, sync included, is captured identically and independently, one record each.
// - Each event record carries its channel number and time since measurement start.
// - Time counts at the finest unit; one clock adds clock period over unit.
// - Record is 32 bits: 6-bit channel field and 25-bit time tag field.
// - On each time tag wrap an overflow record is inserted into the stream.
// - Each channel is blind for its dead time; other channels are unaffected.
// - Each channel has its own front buffer, default 2048 records.
// - Front buffers feed one shared buffer, default 134,217,728 records.
// - A front buffer overflow drops the event and sets a sticky loss flag.
// - A shared buffer overrun ends the running measurement.
`timescale 1ns/1ps
module time_tag_recorder
  import tag_recorder_pkg::*;
#(
  parameter int NUM_CHANS    = NUM_CHANS_DEF,
  parameter int FRONT_DEPTH  = FRONT_DEPTH_DEF,
  parameter int SHARED_DEPTH = SHARED_DEPTH_DEF,
  parameter int TIME_UNIT_PS = RES_PS
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Measurement control
  input  wire logic                 measStart,
  input  wire logic                 measStop,
  input  wire logic                 lossClear,
  // Detector inputs, index 0 is the sync input
  input  wire logic [NUM_CHANS-1:0] photonInputChannels,
  // Record stream to host
  output record_t                   recData,
  output logic                      recValid,
  input  wire logic                 recReady,
  // Status
  output logic                      running,
  output logic                      lossFlag,
  output logic                      overrunFlag
);

  localparam int SEL_W = (NUM_CHANS > 1) ? $clog2(NUM_CHANS) : 1;
  // Tag units per clock; the finest unit differs between model variants
  localparam int TICK  = (TIME_UNIT_PS > 0) ? CLK_PERIOD_PS / TIME_UNIT_PS : 0;

  if (NUM_CHANS < 1 || NUM_CHANS > MAX_CHANS || TICK < 1 || TICK >= (1 << TAG_W)) begin : g_bad
    $error("time_tag_recorder: channel count must be 1..64 and the time unit must fit the clock period");
  end

  // Reset release through two flops
  logic rstMeta_q;
  logic rstN;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // Round robin pick of the next valid channel after the last one served
  function automatic logic [SEL_W-1:0] pickChan(input logic [NUM_CHANS-1:0] v,
                                                input logic [SEL_W-1:0] last);
    int idx;
    logic [SEL_W-1:0] res;
    logic found;
    res   = last;
    found = 1'b0;
    for (int k = 1; k <= NUM_CHANS; k++) begin
      idx = (int'(last) + k) % NUM_CHANS;
      if (!found && v[idx]) begin
        res   = SEL_W'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction : pickChan

  // Measurement run state
  logic abortNow;
  logic running_q;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      running_q <= 1'b0;
    end else if (abortNow || measStop) begin
      running_q <= 1'b0;
    end else if (measStart) begin
      running_q <= 1'b1;
    end
  end

  // Time tag counter, cleared at start so tags count from measurement start
  logic [TAG_W-1:0] tag_q;
  logic [TAG_W:0]   tagSum;
  logic             tagWrap;

  assign tagSum  = {1'b0, tag_q} + (TAG_W + 1)'(TICK);
  assign tagWrap = running_q && tagSum[TAG_W];

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tag_q <= TAG_RESET;
    end else if (measStart && !running_q) begin
      tag_q <= TAG_RESET;
    end else if (running_q) begin
      tag_q <= tagSum[TAG_W-1:0];
    end
  end

  // Per-channel capture with dead time and front buffers
  logic [DEAD_W-1:0]    dead_q [NUM_CHANS];
  logic [NUM_CHANS-1:0] accept;
  logic [NUM_CHANS-1:0] frontInReady;
  logic [NUM_CHANS-1:0] frontOutValid;
  logic [NUM_CHANS-1:0] frontOutReady;
  record_t              frontOut [NUM_CHANS];
  logic [NUM_CHANS-1:0] dropped;

  for (genvar c = 0; c < NUM_CHANS; c++) begin : g_chan
    record_t capRec;

    // Dead time is per channel only, so coincident events all survive
    assign accept[c]  = running_q && photonInputChannels[c] && (dead_q[c] == DEAD_IDLE);
    assign dropped[c] = accept[c] && !frontInReady[c];
    assign capRec     = '{kind: KIND_EVENT, chan: CHAN_W'(c), tag: tag_q};

    always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
        dead_q[c] <= DEAD_IDLE;
      end else if (accept[c]) begin
        dead_q[c] <= DEAD_W'(DEAD_CYC);
      end else if (dead_q[c] != DEAD_IDLE) begin
        dead_q[c] <= dead_q[c] - 1'b1;
      end
    end

    rec_fifo #(
      .WIDTH (REC_W),
      .DEPTH (FRONT_DEPTH)
    ) u_front (
      .clock    (clock),
      .rstN     (rstN),
      .inData   (capRec),
      .inValid  (accept[c]),
      .inReady  (frontInReady[c]),
      .outData  (frontOut[c]),
      .outValid (frontOutValid[c]),
      .outReady (frontOutReady[c])
    );
  end

  // Overflow record waiting for a slot; a new wrap wins over the clear
  logic ovfPending_q;
  logic ovfTaken;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ovfPending_q <= 1'b0;
    end else if (tagWrap) begin
      ovfPending_q <= 1'b1;
    end else if (ovfTaken || (measStart && !running_q)) begin
      ovfPending_q <= 1'b0;
    end
  end

  // Merge into the shared buffer, one record per clock, overflow first
  logic [SEL_W-1:0] lastSel_q;
  logic [SEL_W-1:0] sel;
  logic             anyFront;
  logic             sharedInReady;
  logic             sharedInValid;
  record_t          sharedIn;

  assign sel           = pickChan(frontOutValid, lastSel_q);
  assign anyFront      = |frontOutValid;
  assign sharedInValid = ovfPending_q || anyFront;
  assign ovfTaken      = ovfPending_q && sharedInReady;
  // Stalling on full is what lets a long host pause be detected as overrun
  assign abortNow      = running_q && sharedInValid && !sharedInReady;

  always_comb begin
    frontOutReady = '0;
    if (ovfPending_q) begin
      sharedIn = '{kind: KIND_OVERFLOW, chan: '0, tag: TAG_RESET};
    end else begin
      sharedIn = frontOut[sel];
      frontOutReady[sel] = anyFront && sharedInReady;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      lastSel_q <= '0;
    end else if (!ovfPending_q && anyFront && sharedInReady) begin
      lastSel_q <= sel;
    end
  end

  // Shared buffer toward the host
  record_t sharedOut;
  logic    sharedOutValid;
  logic    sharedOutReady;

  rec_fifo #(
    .WIDTH (REC_W),
    .DEPTH (SHARED_DEPTH)
  ) u_shared (
    .clock    (clock),
    .rstN     (rstN),
    .inData   (sharedIn),
    .inValid  (sharedInValid),
    .inReady  (sharedInReady),
    .outData  (sharedOut),
    .outValid (sharedOutValid),
    .outReady (sharedOutReady)
  );

  // Registered output stage; host back-pressure reaches the shared buffer
  record_t recData_q;
  logic    recValid_q;

  assign sharedOutReady = !recValid_q || recReady;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      recData_q  <= REC_RESET;
      recValid_q <= 1'b0;
    end else if (sharedOutReady) begin
      recData_q  <= sharedOut;
      recValid_q <= sharedOutValid;
    end
  end

  // Sticky status; the event side wins over a clear in the same cycle
  logic lossFlag_q;
  logic overrun_q;

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      lossFlag_q <= 1'b0;
    end else if (|dropped) begin
      lossFlag_q <= 1'b1;
    end else if (lossClear || (measStart && !running_q)) begin
      lossFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      overrun_q <= 1'b0;
    end else if (abortNow) begin
      overrun_q <= 1'b1;
    end else if (measStart && !running_q) begin
      overrun_q <= 1'b0;
    end
  end

  assign recData     = recData_q;
  assign recValid    = recValid_q;
  assign running     = running_q;
  assign lossFlag    = lossFlag_q;
  assign overrunFlag = overrun_q;

endmodule : time_tag_recorder
